// >>> common/pocd_regs.vh
// register map, field layout, reset values and timing counts of the overcurrent block
`ifndef POCD_REGS_VH
`define POCD_REGS_VH

// register indices; byte address is four times the index
`define POCD_IDX_LOCKOUT   14'h30e1
`define POCD_IDX_MINWIDTH  14'h30ea
`define POCD_IDX_WINDOW    14'h30eb
`define POCD_IDX_CTRL      14'h30f0
`define POCD_IDX_STATUS    14'h30f1
`define POCD_IDX_MASK      14'h30f2
`define POCD_IDX_STATE     14'h30f3

// reset values
`define POCD_RST_LOCKOUT   8'h0a
`define POCD_RST_MINWIDTH  4'h5
`define POCD_RST_WINDOW    8'h14
`define POCD_RST_CTRL      9'h000

// field layout
`define POCD_NPORTS        6
`define POCD_CTRL_GANG     8
`define POCD_STATE_GANG    8

// register select codes from the address decoder
`define POCD_SEL_NONE      3'h0
`define POCD_SEL_LOCKOUT   3'h1
`define POCD_SEL_MINWIDTH  3'h2
`define POCD_SEL_WINDOW    3'h3
`define POCD_SEL_CTRL      3'h4
`define POCD_SEL_STATUS    3'h5
`define POCD_SEL_MASK      3'h6
`define POCD_SEL_STATE     3'h7

// bus responses
`define POCD_RESP_OKAY     2'b00
`define POCD_RESP_SLVERR   2'b10

// time base: one step of every timing register is 1 ms
`define POCD_STEP_NS       1000000
`define POCD_CLK_NS        40

`endif

// >>> src/pocd_port.v
// one pin's power drive, start lockout and overcurrent filter
`default_nettype none

module pocd_port
(
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // time base and configuration
  input  wire       tick,         // one cycle every 1 ms
  input  wire [3:0] min_width,    // single pulse width, ms
  input  wire [7:0] window,       // double pulse window, ms
  input  wire [7:0] lockout,      // start lockout, ms
  // control
  input  wire       power_on,     // wanted power state
  // pin
  input  wire       pin_in,
  output reg        pin_oe_n,     // low while driving low
  output reg        pullup_en,
  // result
  output reg        oc_event      // detection, high each cycle a trip condition holds
);

  reg [7:0] lock_cnt;   // remaining lockout, ms
  reg       powered;    // power state of last cycle
  reg [3:0] low_ms;     // ms of unbroken low samples
  reg       was_low;    // previous sample was low
  reg       armed;      // first low group has ended
  reg [7:0] win_cnt;    // remaining double window, ms
  wire      sampling;   // pin is being watched
  wire      low;        // qualified low sample

  assign sampling = powered & power_on & (lock_cnt == 8'h00); // R1 R6
  assign low      = sampling & ~pin_in;

  // pin drive: off means hard low with pull-up off
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_oe_n  <= 1'b0;
      pullup_en <= 1'b0;
    end
    else
    begin
      pin_oe_n  <= power_on;  // R9 R10
      pullup_en <= power_on;  // R9 R10
    end
  end

  // lockout timer restarts at every power-on edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      powered  <= 1'b0;
      lock_cnt <= 8'h00;
    end
    else
    begin
      powered <= power_on;
      if (power_on & ~powered)
        lock_cnt <= lockout;                 // R6 R7
      else if (!power_on)
        lock_cnt <= 8'h00;
      else if (tick && lock_cnt != 8'h00)
        lock_cnt <= lock_cnt - 8'h01;        // R7
    end
  end

  // single and double pulse filters
  always @(posedge aclk)
  begin
    if (!aresetn || !sampling)
    begin
      // idle filters while off or locked out, so ramp glitches are forgotten
      low_ms   <= 4'h0;
      was_low  <= 1'b0;
      armed    <= 1'b0;
      win_cnt  <= 8'h00;
      oc_event <= 1'b0;
    end
    else
    begin
      was_low  <= low;
      oc_event <= 1'b0;
      // continuous low run, saturating
      if (!low)
        low_ms <= 4'h0;
      else if (tick && low_ms != 4'hf)
        low_ms <= low_ms + 4'h1;
      if (low && low_ms >= min_width)
        oc_event <= 1'b1;                    // R2 R4
      // end of a first low group opens the window
      if (was_low && !low && !armed)
      begin
        armed   <= 1'b1;                     // R3
        win_cnt <= window;                   // R5
      end
      else if (armed)
      begin
        if (low)
          oc_event <= 1'b1;                  // R3
        else if (tick)
        begin
          // window of zero closes at the first tick, as a window of one does; software must avoid it
          if (win_cnt <= 8'h01)
            armed <= 1'b0;
          win_cnt <= win_cnt - 8'h01;        // R5
        end
      end
    end
  end

endmodule // pocd_port

`default_nettype wire

// >>> src/pocd_top.v
// port power control and overcurrent detection with an axi4-lite register slave
// Function
// R1: sample pin continuously while port enabled
// R2: long unbroken low pulse flags overcurrent
// R3: two low groups within window flag overcurrent
// R4: pulse width four bits, 1 ms, default 5
// R5: double window eight bits, 1 ms, default 20
// R6: ignore pin during lockout after power-on
// R7: lockout eight bits, 1 ms, default 10
// R8: software never writes zero window or lockout
// R9: power off drives pin low, pull-up off
// R10: power on releases driver, enables pull-up
// R11: poly fuse needs zero power-good delay
// R12: ganged shared pin flags every port
// R13: individual mode is the reset default
// R14: flag holds, port stays off until acknowledged
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "pocd_regs.vh"
`default_nettype none

module pocd_top
#(
  parameter STEP_CYCLES = `POCD_STEP_NS / `POCD_CLK_NS  // clocks per 1 ms step
)
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [15:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [15:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // per-port power and sense pins
  input  wire [5:0]  port_power_sense_pin_in,
  output wire [5:0]  port_power_sense_pin_oe_n,
  output wire [5:0]  port_power_sense_pin_pullup,
  // shared pin for ganged mode
  input  wire        shared_power_pin_in,
  output wire        shared_power_pin_oe_n,
  output wire        shared_power_pin_pullup,
  // interrupt
  output reg         irq
);

  localparam NP = `POCD_NPORTS;

  // configuration and status registers
  reg  [7:0]    lockout;      // start lockout, ms
  reg  [3:0]    min_width;    // single pulse width, ms
  reg  [7:0]    window;       // double pulse window, ms
  reg  [8:0]    ctrl;         // port enables and gang select
  reg  [NP-1:0] oc_flag;      // sticky overcurrent per port
  reg  [NP-1:0] mask;         // interrupt enables
  // bus state
  reg           aw_held;      // address taken, waiting for data
  reg           w_held;       // data taken, waiting for address
  reg  [15:0]   aw_addr;
  reg  [31:0]   w_data;
  reg  [3:0]    w_strb;
  // time base
  reg  [15:0]   step_cnt;
  reg           tick;
  // power decisions
  reg  [NP-1:0] port_power;   // individual port power
  reg           gang_power;   // shared pin power
  wire [NP-1:0] port_event;
  wire          gang_event;
  wire          gang;
  wire [2:0]    wsel;
  wire [2:0]    rsel;
  reg  [NP-1:0] oc_clr;
  reg  [NP-1:0] oc_set;

  // address to register select; used by both read and write paths
  function [2:0] reg_sel;
    input [15:0] addr;
    begin
      case (addr[15:2])
        `POCD_IDX_LOCKOUT:  reg_sel = `POCD_SEL_LOCKOUT;
        `POCD_IDX_MINWIDTH: reg_sel = `POCD_SEL_MINWIDTH;
        `POCD_IDX_WINDOW:   reg_sel = `POCD_SEL_WINDOW;
        `POCD_IDX_CTRL:     reg_sel = `POCD_SEL_CTRL;
        `POCD_IDX_STATUS:   reg_sel = `POCD_SEL_STATUS;
        `POCD_IDX_MASK:     reg_sel = `POCD_SEL_MASK;
        `POCD_IDX_STATE:    reg_sel = `POCD_SEL_STATE;
        default:            reg_sel = `POCD_SEL_NONE;
      endcase
    end
  endfunction

  assign gang = ctrl[`POCD_CTRL_GANG];
  assign wsel = reg_sel(aw_addr);
  assign rsel = reg_sel(s_axi_araddr);

  // 1 ms step generator shared by all filters
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_cnt <= 16'h0000;
      tick     <= 1'b0;
    end
    else if (step_cnt == STEP_CYCLES[15:0] - 16'h0001)
    begin
      step_cnt <= 16'h0000;
      tick     <= 1'b1;
    end
    else
    begin
      step_cnt <= step_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // per-port filters
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1)
    begin : gen_port
      pocd_port u_port
      (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick),
        .min_width (min_width),
        .window    (window),
        .lockout   (lockout),
        .power_on  (port_power[g]),
        .pin_in    (port_power_sense_pin_in[g]),
        .pin_oe_n  (port_power_sense_pin_oe_n[g]),
        .pullup_en (port_power_sense_pin_pullup[g]),
        .oc_event  (port_event[g])
      );
    end
  endgenerate

  // shared pin filter for ganged mode
  pocd_port u_gang
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .min_width (min_width),
    .window    (window),
    .lockout   (lockout),
    .power_on  (gang_power),
    .pin_in    (shared_power_pin_in),
    .pin_oe_n  (shared_power_pin_oe_n),
    .pullup_en (shared_power_pin_pullup),
    .oc_event  (gang_event)
  );

  // power decision: flagged ports stay off until the flag is cleared
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_power <= {NP{1'b0}};
      gang_power <= 1'b0;
    end
    else
    begin
      port_power <= {NP{~gang}} & ctrl[NP-1:0] & ~oc_flag;   // R14 R13
      gang_power <= gang & (|ctrl[NP-1:0]) & ~(|oc_flag);    // R12 R14
    end
  end

  // set and clear terms of the sticky flags
  always @*
  begin
    oc_set = port_event | {NP{gang_event}};                  // R12
    oc_clr = {NP{1'b0}};
    if (aw_held && w_held && !s_axi_bvalid && wsel == `POCD_SEL_STATUS && w_strb[0])
      oc_clr = w_data[NP-1:0];                               // R14
  end

  // write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `POCD_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 16'h0000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        // unmapped addresses answer slverr and store nothing
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == `POCD_SEL_NONE) ? `POCD_RESP_SLVERR : `POCD_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register stores; set beats clear on the flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lockout   <= `POCD_RST_LOCKOUT;   // R7
      min_width <= `POCD_RST_MINWIDTH;  // R4
      window    <= `POCD_RST_WINDOW;    // R5
      ctrl      <= `POCD_RST_CTRL;      // R13
      oc_flag   <= {NP{1'b0}};
      mask      <= {NP{1'b0}};
    end
    else
    begin
      oc_flag <= (oc_flag & ~oc_clr) | oc_set;   // R14
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        // zero in window or lockout is stored as written; keeping it out is software's job
        case (wsel)
          `POCD_SEL_LOCKOUT:  if (w_strb[0]) lockout <= w_data[7:0];    // R7 R8
          `POCD_SEL_MINWIDTH: if (w_strb[0]) min_width <= w_data[3:0];  // R4
          `POCD_SEL_WINDOW:   if (w_strb[0]) window <= w_data[7:0];     // R5 R8
          `POCD_SEL_CTRL:
          begin
            if (w_strb[0])
              ctrl[NP-1:0] <= w_data[NP-1:0];
            if (w_strb[1])
              ctrl[`POCD_CTRL_GANG] <= w_data[`POCD_CTRL_GANG];         // R12
          end
          `POCD_SEL_MASK:     if (w_strb[0]) mask <= w_data[NP-1:0];
          default:            ;
        endcase
      end
    end
  end

  // read channel: answer in the cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `POCD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `POCD_RESP_OKAY;
      case (rsel)
        `POCD_SEL_LOCKOUT:  s_axi_rdata <= {24'h000000, lockout};
        `POCD_SEL_MINWIDTH: s_axi_rdata <= {28'h0000000, min_width};  // R4
        `POCD_SEL_WINDOW:   s_axi_rdata <= {24'h000000, window};
        `POCD_SEL_CTRL:     s_axi_rdata <= {23'h000000, ctrl};
        `POCD_SEL_STATUS:   s_axi_rdata <= {26'h0000000, oc_flag};
        `POCD_SEL_MASK:     s_axi_rdata <= {26'h0000000, mask};
        `POCD_SEL_STATE:    s_axi_rdata <= {23'h000000, gang_power, 2'b00, port_power};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `POCD_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // level interrupt from unmasked flags
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(oc_flag & mask);
  end

endmodule // pocd_top

`default_nettype wire

// >>> sim/pocd_props.sv
// checker of handshake and pin drive relations of the overcurrent block
`default_nettype none
module pocd_props
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // pins and interrupt
  input wire logic [5:0] port_power_sense_pin_oe_n,
  input wire logic [5:0] port_power_sense_pin_pullup,
  input wire logic       shared_power_pin_oe_n,
  input wire logic       shared_power_pin_pullup,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset drives every pin low, gang pin included
  property p_rst; disable iff (1'b0)
    !aresetn |=> s_axi_awready && !s_axi_bvalid && !irq && !shared_power_pin_oe_n
      && port_power_sense_pin_oe_n == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // a driven pin never has its pull-up on
  property p_off_low; (~port_power_sense_pin_oe_n & port_power_sense_pin_pullup) == 6'h00
    && !(!shared_power_pin_oe_n && shared_power_pin_pullup); endproperty
  a_off_low: assert property (p_off_low) else $error("pull-up on while driving");
  // a released pin always has its pull-up on
  property p_on_pull; (port_power_sense_pin_oe_n & ~port_power_sense_pin_pullup) == 6'h00
    && !(shared_power_pin_oe_n && !shared_power_pin_pullup); endproperty
  a_on_pull: assert property (p_on_pull) else $error("released without pull-up");
  // gang pin and port pins never powered together
  property p_gang; !(shared_power_pin_oe_n && port_power_sense_pin_oe_n != 6'h00); endproperty
  a_gang: assert property (p_gang) else $error("gang and port pins both on");
  // powered port 0 survives the first eight cycles of lockout
  property p_lock; $rose(port_power_sense_pin_pullup[0]) |=> port_power_sense_pin_pullup[0] [*8]; endproperty
  a_lock: assert property (p_lock) else $error("port dropped inside lockout");
  // write response holds until taken
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  // read response holds until taken
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  // response two edges after both halves of a write
  property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  // read answer right after address taken
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
endmodule // pocd_props
bind pocd_top pocd_props u_props (.*);
`default_nettype wire

// >>> sim/pocd_switch_model.sv
// power switch model at the far side of the port pins
`default_nettype none
module pocd_switch_model
(
  // clock for the floating pattern
  input  wire logic       aclk,
  // pin drive, bit 6 is the shared pin
  input  wire logic [6:0] oe_n,
  input  wire logic [6:0] pull_en,
  // overcurrent command from the bench
  input  wire logic [6:0] fault,
  // pin levels back
  output var  logic [6:0] pin
);
  logic [6:0] noise = 7'h55; // undriven pin must not look settled
  // floating level flips every cycle
  always @(posedge aclk)
    noise <= ~noise;
  // driven low wins; fault pulls low at once, no power-good delay
  // a released pin follows its pull-up and only floats without it
  always @*
    pin = oe_n & ~fault & (pull_en | noise);
endmodule // pocd_switch_model
`default_nettype wire

// >>> sim/port_overcurrent_detect_tb.sv
// self-checking bench of the overcurrent block with a power switch model
`include "pocd_regs.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module port_overcurrent_detect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam STEP = 20; // clocks per ms, shortened
  logic        aclk, aresetn;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [1:0]  bresp, rresp, eb;
  logic [33:0] er;
  logic [6:0]  fault;
  wire  [6:0]  oe_n, pull, pin;
  int          fails, n_compared, cyc, n;
  logic [1:0]  bq[$]; // expected write responses
  logic [33:0] rq[$]; // expected read response and data
  logic [13:0] idx_t [7] = '{`POCD_IDX_LOCKOUT, `POCD_IDX_MINWIDTH, `POCD_IDX_WINDOW,
    `POCD_IDX_CTRL, `POCD_IDX_STATUS, `POCD_IDX_MASK, `POCD_IDX_STATE};
  logic [31:0] def_t [7] = '{32'h0a, 32'h05, 32'h14, 32'h0, 32'h0, 32'h0, 32'h0};
  pocd_top #(.STEP_CYCLES(STEP)) uut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_power_sense_pin_in(pin[5:0]), .port_power_sense_pin_oe_n(oe_n[5:0]),
    .port_power_sense_pin_pullup(pull[5:0]), .shared_power_pin_in(pin[6]),
    .shared_power_pin_oe_n(oe_n[6]), .shared_power_pin_pullup(pull[6]), .irq(irq)
  );
  pocd_switch_model sw (.aclk(aclk), .oe_n(oe_n), .pull_en(pull), .fault(fault), .pin(pin));
  // 25 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic wt(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // one write, both halves offered together, bready held until answered
  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(r);
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask
  // one read, expectation noted for the watcher
  task automatic rd(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({r, d});
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask
  // fault on a pin for k cycles
  task automatic pulse(input int b, input int k);
    fault[b] <= 1'b1;
    wt(k);
    fault[b] <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watcher: oldest note against each response seen
  always @(posedge aclk)
  begin
    if (bvalid && bready)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready)
    begin
      er = rq.pop_front();
      `CHK("rdata", er, {rresp, rdata})
    end
  end
  // hang guard, well above the run length
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, fault} = '0;
    aresetn = 1'b0;
    rnd = 32'd12116;
    wt(10);
    aresetn <= 1'b1;
    `CHK("pins at reset", 14'h0000, {oe_n, pull})
    for (int i = 0; i < 7; i++)
      rd(idx_t[i], def_t[i], `POCD_RESP_OKAY);
    rd(14'h3000, 32'h0, `POCD_RESP_SLVERR);
    wr(14'h3000, 32'h1, `POCD_RESP_SLVERR);
    wr(`POCD_IDX_MINWIDTH, 32'hff, `POCD_RESP_OKAY);
    rd(`POCD_IDX_MINWIDTH, 32'h0f, `POCD_RESP_OKAY);
    rnd = xs(rnd);
    wr(`POCD_IDX_MASK, rnd, `POCD_RESP_OKAY);
    rd(`POCD_IDX_MASK, {26'h0, rnd[5:0]}, `POCD_RESP_OKAY);
    wr(`POCD_IDX_LOCKOUT, 32'h02, `POCD_RESP_OKAY);
    wr(`POCD_IDX_WINDOW, 32'h03, `POCD_RESP_OKAY);
    rd(`POCD_IDX_WINDOW, 32'h03, `POCD_RESP_OKAY);
    wr(`POCD_IDX_MINWIDTH, 32'h00, `POCD_RESP_OKAY);
    wr(`POCD_IDX_MASK, 32'h01, `POCD_RESP_OKAY);
    // power port 0, fault inside lockout is ignored
    wr(`POCD_IDX_CTRL, 32'h01, `POCD_RESP_OKAY);
    wt(3);
    `CHK("pins on", {7'h01, 7'h01}, {oe_n, pull})
    pulse(0, 12);
    wt(60);
    rd(`POCD_IDX_STATUS, 32'h0, `POCD_RESP_OKAY);
    // zero width: one low sample trips, port held off until acknowledged
    pulse(0, 2);
    wt(6);
    `CHK("trip zero width", 3'b100, {irq, oe_n[0], pull[0]})
    rd(`POCD_IDX_STATUS, 32'h01, `POCD_RESP_OKAY);
    rd(`POCD_IDX_STATE, 32'h00, `POCD_RESP_OKAY);
    wt(40);
    `CHK("held off", 1'b0, oe_n[0])
    wr(`POCD_IDX_MINWIDTH, 32'h05, `POCD_RESP_OKAY);
    wr(`POCD_IDX_STATUS, 32'h01, `POCD_RESP_OKAY);
    wt(3);
    `CHK("ack repowers", 2'b01, {irq, pull[0]})
    wt(60);
    // short low alone is no trip, long low trips after 5 ms
    pulse(0, 40);
    wt(100);
    rd(`POCD_IDX_STATUS, 32'h0, `POCD_RESP_OKAY);
    fault[0] <= 1'b1;
    for (n = 0; n < 200 && oe_n[0]; n++)
      @(posedge aclk);
    fault[0] <= 1'b0;
    // 5 ms on 1 ms ticks, first tick may come early; five cycles from filter to pin
    `CHK("single width", 1'b1, n >= 4 * STEP + 5 && n <= 5 * STEP + 5)
    wr(`POCD_IDX_STATUS, 32'h01, `POCD_RESP_OKAY);
    wt(65);
    // two short lows inside the window trip
    pulse(0, 2);
    wt(10);
    pulse(0, 2);
    wt(6);
    `CHK("double trip", 1'b0, oe_n[0])
    rd(`POCD_IDX_STATUS, 32'h01, `POCD_RESP_OKAY);
    // ganged: shared pin powers and flags every port
    wr(`POCD_IDX_CTRL, 32'h13f, `POCD_RESP_OKAY);
    wr(`POCD_IDX_STATUS, 32'h01, `POCD_RESP_OKAY);
    wt(3);
    `CHK("gang pins", {7'h40, 7'h40}, {oe_n, pull})
    wt(60);
    pulse(6, 120);
    rd(`POCD_IDX_STATUS, 32'h3f, `POCD_RESP_OKAY);
    `CHK("gang irq", 1'b1, irq)
    wt(2);
    end_of_test();
  end
endmodule // port_overcurrent_detect_tb
`default_nettype wire
